// ===== design/front_panel_cfg.svh
// constants for the front panel setting menu
`ifndef FRONT_PANEL_CFG_SVH
`define FRONT_PANEL_CFG_SVH
// ****************************************
// timebase
// ****************************************
`define MCLK_PERIOD_NS 4
`define MS_NS 1000000
`define MS_PER_SEC 1000
`define DEBOUNCE_MS 20
`define HOLD_SHORT_MS 1000
`define HOLD_ENTER_MS 3000
// ****************************************
// buttons
// ****************************************
`define BTN_N 5
`define BTN_SHIFT 0
`define BTN_UP 1
`define BTN_NEXT 2
`define BTN_PREV 3
`define BTN_MAXMIN 4
// ****************************************
// digits and reset values
// ****************************************
`define DIG_NINE 4'h9
`define DIG_ZERO 4'h0
`define DIG_MINUS 4'ha
`define SIGN_POS 3'h5
`define RET_SEC_RST 8'h0f
`define LOCK_RST 2'h1
// ****************************************
// register offsets
// ****************************************
`define REG_CTRL 8'h00
`define REG_KIND 8'h04
`define REG_HIDE 8'h08
`define REG_LIMIT 8'h0c
`define REG_STATUS 8'h10
`define REG_SELMAX 8'h14
`define VAL_PAGE 3'h1
`endif

// ===== design/panel_pkg.sv
// types shared by the front panel setting menu
package panel_pkg;
	typedef enum logic [1:0] {st_measure, st_show, st_standby} state_t;
	typedef enum logic {grp_initial, grp_alarm} group_t;
	typedef enum logic [1:0] {
		lock_level_open,
		lock_level_partial,
		lock_level_full
	} lock_t;
endpackage

// ===== design/button_sense.sv
// debounced button events: short press, 1 s hold and 3 s hold
`timescale 1ns/1ns
`include "front_panel_cfg.svh"
module button_sense #(
	parameter int N        = `BTN_N,
	parameter int DEB_MS   = `DEBOUNCE_MS,
	parameter int SHORT_MS = `HOLD_SHORT_MS,
	parameter int LONG_MS  = `HOLD_ENTER_MS
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic         ms_tick,
	input  wire logic [N-1:0] btn,
	output logic      [N-1:0] level,
	output logic      [N-1:0] press_p,
	output logic      [N-1:0] short_p,
	output logic      [N-1:0] hold1_p,
	output logic      [N-1:0] hold3_p
);
	localparam int CW = $clog2(LONG_MS + 1);
	localparam logic [CW-1:0] DEB   = CW'(DEB_MS);
	localparam logic [CW-1:0] SHORT = CW'(SHORT_MS);
	localparam logic [CW-1:0] LONG  = CW'(LONG_MS);
	// ****************************************
	// one filter and hold timer per button
	// ****************************************
	for (genvar b = 0; b < N; b++) begin : g_btn
		logic          stab_q, stab_d;
		logic [CW-1:0] deb_q, deb_d, hold_q, hold_d;
		logic          pr_q, pr_d, sh_q, sh_d, h1_q, h1_d, h3_q, h3_d;
		// level must disagree for DEB ms before it is taken
		always_comb begin
			stab_d = stab_q;
			deb_d  = deb_q;
			hold_d = hold_q;
			pr_d   = 1'b0;
			sh_d   = 1'b0;
			h1_d   = 1'b0;
			h3_d   = 1'b0;
			if (btn[b] == stab_q) begin
				deb_d = '0;
			end else if (ms_tick) begin
				deb_d = deb_q + 1'b1;
			end
			if (ms_tick && btn[b] != stab_q && deb_q + 1'b1 >= DEB) begin
				stab_d = btn[b];
				deb_d  = '0;
				hold_d = '0;
				pr_d   = btn[b];
				// release before the hold time counts as short
				sh_d   = !btn[b] && hold_q < SHORT;
			end else if (ms_tick && stab_q && hold_q != LONG) begin
				hold_d = hold_q + 1'b1;
				h1_d   = hold_q + 1'b1 == SHORT;
				h3_d   = hold_q + 1'b1 == LONG;
			end
		end
		always_ff @(posedge mclk) begin
			if (!nrst) begin
				stab_q <= 1'b0;
				deb_q  <= '0;
				hold_q <= '0;
				pr_q   <= 1'b0;
				sh_q   <= 1'b0;
				h1_q   <= 1'b0;
				h3_q   <= 1'b0;
			end else begin
				stab_q <= stab_d;
				deb_q  <= deb_d;
				hold_q <= hold_d;
				pr_q   <= pr_d;
				sh_q   <= sh_d;
				h1_q   <= h1_d;
				h3_q   <= h3_d;
			end
		end
		assign level[b]   = stab_q;
		assign press_p[b] = pr_q;
		assign short_p[b] = sh_q;
		assign hold1_p[b] = h1_q;
		assign hold3_p[b] = h3_q;
	end
endmodule

// ===== design/front_panel_setting_menu.sv
// front panel setting state machine with wishbone control registers
//
// Contract
// - prev/up held 3 s leaves measuring and enters initial setting; the code enters on prev held 3 s only, up held does not
// - measurement halts in setting modes and restarts on return
// - shift blinks a selection value; up steps to next choice
// - short next/prev commits and moves to following or preceding item
// - next/prev held 1 s commits and returns to measuring
// - numeric entry starts at top digit; shift moves blink right
// - up adds one; initial mode top digit shows minus after nine
// - alarm setpoint digits all include minus after nine
// - minus in any digit but the top one is invalid
// - invalid indicator blinks while shown value is out of range
// - address and timer style values beyond limit are invalid
// - alarm mode obeys open, partial and full lock levels
// - lock level resets to partial
// - idle period in standby commits and stops blinking
// - idle period in other setting modes returns to measuring
// - max/min held 1 s in standby restores without commit
// - dc and alarm outputs hold in setting; bcd undefined
// - alarm indicators keep the status latched before setting
// - no mode change while parameter error is shown; the code only blocks moves to and from measuring, not into or out of standby
// - sequence skips hidden and locked parameters
// - sub display shows a parameter identifier
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "front_panel_cfg.svh"
module front_panel_setting_menu import panel_pkg::*; #(
	parameter int N_PARAMS   = 8,
	parameter int DC_W       = 16,
	parameter int ALM_W      = 5,
	parameter int CYC_PER_MS = `MS_NS / `MCLK_PERIOD_NS
) (
	input  wire logic                mclk,
	input  wire logic                nrst,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [`BTN_N-1:0]   btn,
	input  wire logic                perr,
	input  wire logic [DC_W-1:0]     dc_in,
	input  wire logic [ALM_W-1:0]    alarm_in,
	output logic      [DC_W-1:0]     dc_out,
	output logic      [ALM_W-1:0]    alarm_out,
	output logic                     measure_run,
	output logic                     bcd_valid,
	output logic      [23:0]         disp_value,
	output logic      [5:0]          blink_digit,
	output logic                     blink_all,
	output logic                     invalid_value_indicator,
	output logic      [3:0]          sub_display
);
	localparam int IW = $clog2(N_PARAMS);
	localparam int G  = N_PARAMS / 2;
	localparam int MW = $clog2(CYC_PER_MS);
	localparam logic [MW-1:0] MS_LAST = MW'(CYC_PER_MS - 1);
	localparam logic [9:0] SEC_LAST = 10'(`MS_PER_SEC - 1);

	// ****************************************
	// timebase
	// ****************************************
	logic [MW-1:0] ms_cnt_q, ms_cnt_d;
	logic [9:0]    sec_cnt_q, sec_cnt_d;
	logic          ms_tick_q, ms_tick_d, sec_tick_q, sec_tick_d;
	logic          idle_rst;
	// millisecond and second strobes from mclk
	always_comb begin
		ms_tick_d  = ms_cnt_q == MS_LAST;
		ms_cnt_d   = ms_tick_d ? '0 : ms_cnt_q + 1'b1;
		sec_tick_d = 1'b0;
		sec_cnt_d  = sec_cnt_q;
		// restart on activity so no idle period is cut short
		if (idle_rst) begin
			sec_cnt_d = '0;
		end else if (ms_tick_q) begin
			sec_tick_d = sec_cnt_q == SEC_LAST;
			sec_cnt_d  = sec_tick_d ? '0 : sec_cnt_q + 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ms_cnt_q   <= '0;
			sec_cnt_q  <= '0;
			ms_tick_q  <= 1'b0;
			sec_tick_q <= 1'b0;
		end else begin
			ms_cnt_q   <= ms_cnt_d;
			sec_cnt_q  <= sec_cnt_d;
			ms_tick_q  <= ms_tick_d;
			sec_tick_q <= sec_tick_d;
		end
	end

	// ****************************************
	// buttons
	// ****************************************
	logic [`BTN_N-1:0] lvl, prs, shrt, h1, h3;
	button_sense #(
		.N        (`BTN_N),
		.DEB_MS   (`DEBOUNCE_MS),
		.SHORT_MS (`HOLD_SHORT_MS),
		.LONG_MS  (`HOLD_ENTER_MS)
	) u_btn (
		.mclk    (mclk),
		.nrst    (nrst),
		.ms_tick (ms_tick_q),
		.btn     (btn),
		.level   (lvl),
		.press_p (prs),
		.short_p (shrt),
		.hold1_p (h1),
		.hold3_p (h3)
	);

	// ****************************************
	// control registers
	// ****************************************
	lock_t               lock_q, lock_d;
	logic [7:0]          ret_q, ret_d;
	logic [N_PARAMS-1:0] kind_q, kind_d, hide_q, hide_d;
	logic [N_PARAMS-1:0] lmask_q, lmask_d, rmask_q, rmask_d;
	logic [23:0]         limit_q, limit_d;
	logic [3:0]          selmax_q, selmax_d;
	logic                ack_q, ack_d;
	logic [31:0]         rdat_q, rdat_d, rb, wv;
	state_t              state_q;
	group_t              grp_q;
	logic [IW-1:0]       pidx_q;
	logic [2:0]          dpos_q;
	logic [23:0]         edit_q, shown;
	logic [23:0]         value_q [N_PARAMS];
	logic                bad;
	// register reads, byte-lane merged writes; unmapped reads zero
	always_comb begin
		lock_d   = lock_q;
		ret_d    = ret_q;
		kind_d   = kind_q;
		hide_d   = hide_q;
		lmask_d  = lmask_q;
		rmask_d  = rmask_q;
		limit_d  = limit_q;
		selmax_d = selmax_q;
		rb       = '0;
		unique case (wb_adr_i)
			`REG_CTRL:   rb = {16'h0, ret_q, 6'h0, lock_q};
			`REG_KIND:   rb = 32'(kind_q);
			`REG_HIDE:   rb = {16'h0, 8'(lmask_q), 8'(hide_q)};
			`REG_LIMIT:  rb = {8'(rmask_q), limit_q};
			`REG_STATUS: rb = {16'h0, bad, dpos_q, 2'(state_q),
				grp_q, 6'(pidx_q), 3'h0};
			`REG_SELMAX: rb = {28'h0, selmax_q};
			default: begin
				if (wb_adr_i[7:5] == `VAL_PAGE && 32'(wb_adr_i[4:2]) < N_PARAMS)
					rb = {8'h0, value_q[IW'(wb_adr_i[4:2])]};
			end
		endcase
		for (int i = 0; i < 4; i++) begin
			wv[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : rb[i*8 +: 8];
		end
		ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
		rdat_d = ack_d ? rb : '0;
		if (ack_d && wb_we_i) begin
			unique case (wb_adr_i)
				`REG_CTRL: begin
					// a level code above full stays full
					lock_d = wv[1:0] > 2'(lock_level_full) ?
						lock_level_full : lock_t'(wv[1:0]);
					ret_d  = wv[15:8];
				end
				`REG_KIND: kind_d = wv[N_PARAMS-1:0];
				`REG_HIDE: begin
					hide_d  = wv[N_PARAMS-1:0];
					lmask_d = wv[8 +: N_PARAMS];
				end
				`REG_LIMIT: begin
					limit_d = wv[23:0];
					rmask_d = wv[24 +: N_PARAMS];
				end
				`REG_SELMAX: selmax_d = wv[3:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lock_q   <= lock_t'(`LOCK_RST);
			ret_q    <= `RET_SEC_RST;
			kind_q   <= '0;
			hide_q   <= '0;
			lmask_q  <= '0;
			rmask_q  <= '0;
			limit_q  <= '0;
			selmax_q <= '0;
			ack_q    <= 1'b0;
			rdat_q   <= '0;
		end else begin
			lock_q   <= lock_d;
			ret_q    <= ret_d;
			kind_q   <= kind_d;
			hide_q   <= hide_d;
			lmask_q  <= lmask_d;
			rmask_q  <= rmask_d;
			limit_q  <= limit_d;
			selmax_q <= selmax_d;
			ack_q    <= ack_d;
			rdat_q   <= rdat_d;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ****************************************
	// parameter walk helpers
	// ****************************************
	// nearest visible entry in the group, wrapping inside it
	function automatic logic [IW-1:0] step_vis(input logic [IW-1:0] cur,
			input logic up, input logic [N_PARAMS-1:0] vis, input group_t g);
		int lo, loc, c;
		logic [IW-1:0] r;
		r   = cur;
		lo  = (g == grp_alarm) ? G : 0;
		loc = int'(cur) - lo;
		for (int i = G; i >= 1; i--) begin
			c = up ? (loc + i) % G : (loc - i + G) % G;
			if (vis[lo + c])
				r = IW'(lo + c);
		end
		return r;
	endfunction

	// minus off the top digit, selection past its last, value over limit
	function automatic logic out_of_range(input logic [23:0] v,
			input logic [IW-1:0] p);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (v[i*4 +: 4] == `DIG_MINUS)
				r = 1'b1;
		end
		if (kind_q[p] && v[3:0] > selmax_q)
			r = 1'b1;
		if (!kind_q[p] && rmask_q[p] && v > limit_q)
			r = 1'b1;
		return r;
	endfunction

	// ****************************************
	// menu state machine
	// ****************************************
	state_t              state_d;
	group_t              grp_d;
	logic [IW-1:0]       pidx_d;
	logic [2:0]          dpos_d;
	logic [23:0]         edit_d;
	logic [23:0]         value_d [N_PARAMS];
	logic [7:0]          idle_q, idle_d;
	logic [N_PARAMS-1:0] vis_i, vis_a, vis;
	logic                tout, nav_h, nav_s;
	logic [3:0]          dig;
	// hidden by option or dc config, plus partial lock in alarm mode
	always_comb begin
		vis_i = ~hide_q;
		vis_a = ~hide_q &
			~(lock_q == lock_level_partial ? lmask_q : '0);
		vis   = grp_q == grp_alarm ? vis_a : vis_i;
		shown = state_q == st_standby ? edit_q : value_q[pidx_q];
		bad   = state_q != st_measure && out_of_range(shown, pidx_q);
	end
	// one event per cycle; refusals leave state as it was
	always_comb begin
		state_d = state_q;
		grp_d   = grp_q;
		pidx_d  = pidx_q;
		dpos_d  = dpos_q;
		edit_d  = edit_q;
		value_d = value_q;
		tout    = ret_q != 8'h0 && idle_q >= ret_q;
		nav_h   = h1[`BTN_NEXT] || h1[`BTN_PREV];
		nav_s   = shrt[`BTN_NEXT] || shrt[`BTN_PREV];
		dig     = edit_q[{dpos_q, 2'b00} +: 4];
		idle_rst = |lvl || |shrt || state_q == st_measure ||
			(state_q == st_standby && tout);
		if (idle_rst)
			idle_d = '0;
		else if (sec_tick_q && idle_q != 8'hff)
			idle_d = idle_q + 1'b1;
		else
			idle_d = idle_q;
		unique case (state_q)
			st_measure: begin
				if (!perr && h3[`BTN_PREV] && |vis_i[G-1:0]) begin
					state_d = st_show;
					grp_d   = grp_initial;
					pidx_d  = step_vis(IW'(G - 1), 1'b1, vis_i, grp_initial);
				end else if (!perr && h3[`BTN_NEXT] &&
						lock_q != lock_level_full &&
						|vis_a[N_PARAMS-1:G]) begin
					state_d = st_show;
					grp_d   = grp_alarm;
					pidx_d  = step_vis(IW'(N_PARAMS - 1), 1'b1, vis_a, grp_alarm);
				end
			end
			st_show: begin
				if (!perr && (nav_h || tout)) begin
					state_d = st_measure;
				end else if (nav_s) begin
					pidx_d = step_vis(pidx_q, shrt[`BTN_NEXT], vis, grp_q);
				end else if (prs[`BTN_SHIFT]) begin
					state_d = st_standby;
					edit_d  = value_q[pidx_q];
					dpos_d  = `SIGN_POS;
				end
			end
			st_standby: begin
				if (h1[`BTN_MAXMIN]) begin
					state_d = st_show;
				end else if (nav_h && !bad && !perr) begin
					value_d[pidx_q] = edit_q;
					state_d = st_measure;
				end else if (nav_s && !bad) begin
					value_d[pidx_q] = edit_q;
					state_d = st_show;
					pidx_d  = step_vis(pidx_q, shrt[`BTN_NEXT], vis, grp_q);
				end else if (tout) begin
					// an out of range edit is dropped, never stored
					if (!bad)
						value_d[pidx_q] = edit_q;
					state_d = st_show;
					idle_d  = '0;
				end else if (prs[`BTN_UP] && kind_q[pidx_q]) begin
					edit_d = {20'h0, edit_q[3:0] >= selmax_q ?
						`DIG_ZERO : edit_q[3:0] + 1'b1};
				end else if (prs[`BTN_UP]) begin
					if (dig == `DIG_NINE &&
							(grp_q == grp_alarm || dpos_q == `SIGN_POS))
						dig = `DIG_MINUS;
					else if (dig >= `DIG_NINE)
						dig = `DIG_ZERO;
					else
						dig = dig + 1'b1;
					edit_d[{dpos_q, 2'b00} +: 4] = dig;
				end else if (prs[`BTN_SHIFT] && !kind_q[pidx_q]) begin
					dpos_d = dpos_q == 3'h0 ? `SIGN_POS : dpos_q - 1'b1;
				end
			end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q <= st_measure;
			grp_q   <= grp_initial;
			pidx_q  <= '0;
			dpos_q  <= `SIGN_POS;
			edit_q  <= '0;
			idle_q  <= '0;
			for (int i = 0; i < N_PARAMS; i++)
				value_q[i] <= '0;
		end else begin
			state_q <= state_d;
			grp_q   <= grp_d;
			pidx_q  <= pidx_d;
			dpos_q  <= dpos_d;
			edit_q  <= edit_d;
			idle_q  <= idle_d;
			value_q <= value_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	logic [DC_W-1:0]  dc_q;
	logic [ALM_W-1:0] alm_q;
	logic             run_q, bcdv_q, ball_q, ng_q;
	logic [23:0]      disp_q;
	logic [5:0]       bdig_q;
	logic [3:0]       sd_q;
	// dc and alarm outputs freeze at their last measured values while setting
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			dc_q   <= '0;
			alm_q  <= '0;
			run_q  <= 1'b1;
			bcdv_q <= 1'b0;
			disp_q <= '0;
			bdig_q <= '0;
			ball_q <= 1'b0;
			ng_q   <= 1'b0;
			sd_q   <= '0;
		end else begin
			run_q  <= state_q == st_measure;
			dc_q   <= state_q == st_measure ? dc_in : dc_q;
			alm_q  <= state_q == st_measure ? alarm_in : alm_q;
			bcdv_q <= state_q == st_measure;
			disp_q <= state_q == st_measure ? '0 : shown;
			bdig_q <= state_q == st_standby && !kind_q[pidx_q] ?
				6'h01 << dpos_q : 6'h00;
			ball_q <= state_q == st_standby && kind_q[pidx_q];
			ng_q   <= bad;
			sd_q   <= state_q == st_measure ? 4'h0 :
				{1'b1, 3'(pidx_q)};
		end
	end
	assign dc_out                  = dc_q;
	assign alarm_out               = alm_q;
	assign measure_run             = run_q;
	assign bcd_valid               = bcdv_q;
	assign disp_value              = disp_q;
	assign blink_digit             = bdig_q;
	assign blink_all               = ball_q;
	assign invalid_value_indicator = ng_q;
	assign sub_display             = sd_q;
endmodule

// ===== test/panel_checker.sv
// concurrent checks on the front panel setting menu ports
`timescale 1ns/1ns
`include "front_panel_cfg.svh"
module panel_checker #(
	parameter int DC_W  = 16,
	parameter int ALM_W = 5
) (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic [31:0]       wb_dat_o,
	input  wire logic              wb_ack_o,
	input  wire logic [`BTN_N-1:0] btn,
	input  wire logic              perr,
	input  wire logic [DC_W-1:0]   dc_in,
	input  wire logic [ALM_W-1:0]  alarm_in,
	input  wire logic [DC_W-1:0]   dc_out,
	input  wire logic [ALM_W-1:0]  alarm_out,
	input  wire logic              measure_run,
	input  wire logic              bcd_valid,
	input  wire logic [23:0]       disp_value,
	input  wire logic [5:0]        blink_digit,
	input  wire logic [3:0]        sub_display
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// a fresh request, then a single-cycle answer
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	bus_ack_a: assert property (req_s |=> ack_s)
		else $error("bus answer not a one cycle pulse");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	entry_cause_a: assert property (
		$fell(measure_run) |-> $past(btn[`BTN_PREV] || btn[`BTN_NEXT]))
		else $error("left measuring without a held button");
	perr_block_a: assert property (
		$changed(measure_run) && $past(nrst) |-> !$past(perr))
		else $error("mode changed while parameter error shown");
	bcd_off_a: assert property (!measure_run |-> !bcd_valid)
		else $error("bcd valid in a setting mode");
	out_freeze_a: assert property (
		!measure_run && !$past(measure_run)
		|-> $stable(dc_out) && $stable(alarm_out))
		else $error("outputs moved during setting");
	out_follow_a: assert property (
		measure_run && $past(measure_run) && $past(nrst)
		|-> dc_out == $past(dc_in) && alarm_out == $past(alarm_in))
		else $error("outputs not following while measuring");
	sub_show_a: assert property (
		sub_display[3] == !measure_run)
		else $error("sub display marker wrong for mode");
	blink_one_a: assert property ($onehot0(blink_digit))
		else $error("more than one digit blinking");
	blink_move_a: assert property (
		blink_digit != 6'h0 && $past(blink_digit) != 6'h0
		&& $past(blink_digit) != 6'h01 && $changed(blink_digit)
		|-> blink_digit == ($past(blink_digit) >> 1))
		else $error("blink did not move one digit right");
endmodule

// ===== test/operator_model.sv
// operator pressing the front panel buttons
`timescale 1ns/1ns
`include "front_panel_cfg.svh"
module operator_model #(
	parameter int CPM = 4
) (
	input  wire logic              mclk,
	output logic      [`BTN_N-1:0] btn
);
	// ****************************************
	// button actions
	// ****************************************
	// all released at power up
	initial begin
		btn = '0;
	end

	// press one button for ms, then a gap long enough for release debounce
	task automatic push(input int b, input int ms);
		@(posedge mclk);
		btn[b] <= 1'b1;
		repeat (ms * CPM) @(posedge mclk);
		btn[b] <= 1'b0;
		repeat (60 * CPM) @(posedge mclk);
	endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the front panel setting menu
`timescale 1ns/1ns
`include "front_panel_cfg.svh"
module tb;
	// ****************************************
	// signals
	// ****************************************
	localparam int CPM   = 2;
	localparam int LIMIT = 60000;
	logic              mclk = 1'b0;
	logic              nrst;
	logic              wb_cyc_i;
	logic              wb_stb_i;
	logic              wb_we_i;
	logic [7:0]        wb_adr_i;
	logic [3:0]        wb_sel_i;
	logic [31:0]       wb_dat_i;
	logic [31:0]       wb_dat_o;
	logic              wb_ack_o;
	logic [`BTN_N-1:0] btn;
	logic              perr;
	logic [15:0]       dc_in;
	logic [15:0]       dc_out;
	logic [4:0]        alarm_in;
	logic [4:0]        alarm_out;
	logic              measure_run;
	logic              bcd_valid;
	logic [23:0]       disp_value;
	logic [5:0]        blink_digit;
	logic              blink_all;
	logic              invalid_value_indicator;
	logic [3:0]        sub_display;
	int                err_total = 0;
	int                n_compared = 0;
	int                cyc_n = 0;

	front_panel_setting_menu #(.CYC_PER_MS(CPM)) uut (
		.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .btn(btn), .perr(perr), .dc_in(dc_in),
		.alarm_in(alarm_in), .dc_out(dc_out), .alarm_out(alarm_out),
		.measure_run(measure_run), .bcd_valid(bcd_valid),
		.disp_value(disp_value), .blink_digit(blink_digit),
		.blink_all(blink_all),
		.invalid_value_indicator(invalid_value_indicator),
		.sub_display(sub_display));
	operator_model #(.CPM(CPM)) op (.mclk(mclk), .btn(btn));

	// ****************************************
	// tasks
	// ****************************************
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// classic cycle: hold the request until ack is sampled high
	task automatic wb_xfer(input logic we, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		chk("bus ack", 32'h1, 32'(wb_ack_o));
	endtask
	task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp,
			input string what);
		logic [31:0] q;
		wb_xfer(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask
	task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask
	task automatic tap(input int b);
		op.push(b, 40);
	endtask
	task automatic done_test(input string name);
		$display("test %s done, mismatches so far %0d", name, err_total);
	endtask

	// clock at 250 MHz
	initial begin
		forever #2 mclk = ~mclk;
	end

	// hang guard sized to the longest expected run
	always @(posedge mclk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == LIMIT) begin
			err_total++;
			give_verdict();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		perr = 1'b0;
		dc_in = 16'h0;
		alarm_in = 5'h00;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		chk("measure_run", 32'h1, 32'(measure_run));
		wb_rd(`REG_CTRL, 32'h0000_0f01, "ctrl reset");
		wb_rd(8'h80, 32'h0, "unmapped");
		wb_wr(8'h20, 32'h0000_00ff);
		wb_rd(8'h20, 32'h0, "value0 read only");
		wb_wr(`REG_CTRL, 32'h0000_0103);
		wb_rd(`REG_CTRL, 32'h0000_0102, "ctrl lock clamp");
		wb_wr(`REG_CTRL, 32'h0000_0101);
		wb_wr(`REG_KIND, 32'h1);
		wb_wr(`REG_HIDE, 32'h4);
		wb_wr(`REG_LIMIT, 32'h0205_0000);
		wb_wr(`REG_SELMAX, 32'h3);
		done_test("registers");
		dc_in <= 16'h1234;
		alarm_in <= 5'h0a;
		op.push(`BTN_PREV, 3100);
		chk("measure_run", 32'h0, 32'(measure_run));
		chk("bcd_valid", 32'h0, 32'(bcd_valid));
		chk("sub_display", 32'h8, 32'(sub_display));
		dc_in <= 16'h5678;
		alarm_in <= 5'h15;
		repeat (CPM) @(posedge mclk);
		chk("dc_out", 32'h1234, 32'(dc_out));
		chk("alarm_out", 32'h0a, 32'(alarm_out));
		done_test("enter");
		tap(`BTN_SHIFT);
		chk("blink_all", 32'h1, 32'(blink_all));
		tap(`BTN_UP);
		chk("disp_value", 32'h1, 32'(disp_value));
		tap(`BTN_NEXT);
		chk("sub_display", 32'h9, 32'(sub_display));
		wb_rd(8'h20, 32'h1, "value0");
		done_test("selection");
		tap(`BTN_SHIFT);
		chk("blink_digit", 32'h20, 32'(blink_digit));
		tap(`BTN_UP);
		chk("disp_value", 32'h100000, 32'(disp_value));
		chk("invalid", 32'h1, 32'(invalid_value_indicator));
		repeat (9) tap(`BTN_UP);
		chk("disp_value", 32'ha00000, 32'(disp_value));
		tap(`BTN_UP);
		chk("disp_value", 32'h0, 32'(disp_value));
		chk("invalid", 32'h0, 32'(invalid_value_indicator));
		tap(`BTN_SHIFT);
		chk("blink_digit", 32'h10, 32'(blink_digit));
		tap(`BTN_UP);
		chk("disp_value", 32'h010000, 32'(disp_value));
		tap(`BTN_NEXT);
		chk("sub_display", 32'hb, 32'(sub_display));
		wb_rd(8'h24, 32'h010000, "value1");
		tap(`BTN_PREV);
		chk("sub_display", 32'h9, 32'(sub_display));
		done_test("numeric");
		tap(`BTN_SHIFT);
		tap(`BTN_SHIFT);
		tap(`BTN_UP);
		repeat (1200 * CPM) @(posedge mclk);
		chk("blink_digit", 32'h0, 32'(blink_digit));
		wb_rd(8'h24, 32'h020000, "value1");
		tap(`BTN_SHIFT);
		tap(`BTN_SHIFT);
		tap(`BTN_UP);
		op.push(`BTN_MAXMIN, 1100);
		chk("blink_digit", 32'h0, 32'(blink_digit));
		chk("disp_value", 32'h020000, 32'(disp_value));
		wb_rd(8'h24, 32'h020000, "value1");
		done_test("timeout abort");
		repeat (1200 * CPM) @(posedge mclk);
		chk("measure_run", 32'h1, 32'(measure_run));
		repeat (2) @(posedge mclk);
		chk("dc_out", 32'h5678, 32'(dc_out));
		perr <= 1'b1;
		op.push(`BTN_PREV, 3100);
		chk("measure_run", 32'h1, 32'(measure_run));
		perr <= 1'b0;
		op.push(`BTN_PREV, 3100);
		op.push(`BTN_NEXT, 1100);
		chk("measure_run", 32'h1, 32'(measure_run));
		wb_wr(`REG_CTRL, 32'h0000_0102);
		op.push(`BTN_NEXT, 3100);
		chk("measure_run", 32'h1, 32'(measure_run));
		done_test("returns");
		wb_wr(`REG_CTRL, 32'h0000_0101);
		wb_wr(`REG_HIDE, 32'h0000_1004);
		op.push(`BTN_NEXT, 3100);
		chk("sub_display", 32'hd, 32'(sub_display));
		tap(`BTN_SHIFT);
		tap(`BTN_SHIFT);
		repeat (10) tap(`BTN_UP);
		chk("disp_value", 32'h0a0000, 32'(disp_value));
		chk("invalid", 32'h1, 32'(invalid_value_indicator));
		tap(`BTN_NEXT);
		chk("blink_digit", 32'h10, 32'(blink_digit));
		op.push(`BTN_MAXMIN, 1100);
		chk("disp_value", 32'h0, 32'(disp_value));
		repeat (1200 * CPM) @(posedge mclk);
		chk("measure_run", 32'h1, 32'(measure_run));
		done_test("alarm");
		give_verdict();
	end
endmodule

bind front_panel_setting_menu panel_checker #(
	.DC_W(DC_W),
	.ALM_W(ALM_W)
) chk_i (
	.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .btn(btn), .perr(perr),
	.dc_in(dc_in), .alarm_in(alarm_in), .dc_out(dc_out),
	.alarm_out(alarm_out), .measure_run(measure_run),
	.bcd_valid(bcd_valid), .disp_value(disp_value),
	.blink_digit(blink_digit), .sub_display(sub_display));
